// ---- dv/rbs_reset_brownout_sequencer_tb.sv ----
`timescale 1ns/1ps

module rbs_reset_brownout_sequencer_tb;
  import rbs_pkg::*;

  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam int PW = 20; // short power-up count keeps the run brief
  localparam int WR_TURN = 3; // sample points until the write answer
  localparam int RD_TURN = 2; // sample points until the read answer
  logic aclk, aresetn;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [3:0] s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic por_active, brownout_below, brownout_circuit_ready, low_power_brownout_below, ext_reset_pin_n;
  logic [1:0] brownout_mode_sel;
  logic powerup_timer_disable_n, brownout_level_sel, low_power_brownout_n, ext_reset_enable, sleep_mode;
  logic core_reset_n, wake_hold, brownout_detector_en, bandgap_force_on;
  logic brownout_level_out, low_power_brownout_en, brownout_cause_n;
  int mismatches, n_tests, n;

  rbs_reset_brownout_sequencer #(.POWERUP_TIMER_CYCLES(PW)) dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .por_active, .brownout_below, .brownout_circuit_ready, .low_power_brownout_below, .ext_reset_pin_n,
    .brownout_mode_sel, .powerup_timer_disable_n, .brownout_level_sel, .low_power_brownout_n,
    .ext_reset_enable, .sleep_mode, .core_reset_n, .wake_hold, .brownout_detector_en, .bandgap_force_on,
    .brownout_level_out, .low_power_brownout_en, .brownout_cause_n
  );

  // clock, 20 ns period
  initial begin
    aclk = 1'h0;
    forever #10 aclk = ~aclk;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict;
    if (mismatches == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask

  // write: handshakes judged just before the edge, so no race with the slave
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    logic ta, tw, done;
    k = 0;
    done = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!done) begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      done = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      k++;
    end
    s_axi_bready <= 1'h0;
    chk(k, WR_TURN);
    chk(rs, er);
  endtask

  // read and compare data and response
  task automatic rdchk(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    int k;
    logic ta, done;
    k = 0;
    done = 1'h0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!done) begin
      @(negedge aclk);
      ta = s_axi_arvalid & s_axi_arready;
      done = s_axi_rvalid;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'h0;
      k++;
    end
    s_axi_rready <= 1'h0;
    chk(k, RD_TURN);
    chk(rd, ed);
    chk(rs, er);
  endtask

  // cycles until the core leaves reset, bounded
  task automatic run_wait(output int c);
    c = 0;
    while (c < 300) begin
      @(negedge aclk);
      if (core_reset_n === 1'h1) break;
      c++;
    end
  endtask

  // power-on style reset with a fresh configuration word
  task automatic do_reset(input logic [1:0] m, input logic pt, input logic lp, input logic rdy);
    @(posedge aclk);
    aresetn <= 1'h0;
    por_active <= 1'h1;
    brownout_mode_sel <= m;
    powerup_timer_disable_n <= pt;
    low_power_brownout_n <= lp;
    brownout_circuit_ready <= rdy;
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    cyc(3);
    por_active <= 1'h0;
  endtask

  // hang guard, well beyond the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    print_verdict;
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    mismatches = 0;
    n_tests = 0;
    aresetn = 1'h0;
    s_axi_awaddr = 4'h0;
    s_axi_araddr = 4'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_awvalid = 1'h0;
    s_axi_wvalid = 1'h0;
    s_axi_bready = 1'h0;
    s_axi_arvalid = 1'h0;
    s_axi_rready = 1'h0;
    por_active = 1'h1;
    brownout_below = 1'h0;
    brownout_circuit_ready = 1'h1;
    low_power_brownout_below = 1'h0;
    ext_reset_pin_n = 1'h1;
    brownout_mode_sel = MODE_OFF;
    powerup_timer_disable_n = 1'h0;
    brownout_level_sel = 1'h1;
    low_power_brownout_n = 1'h1;
    ext_reset_enable = 1'h1;
    sleep_mode = 1'h0;
    // mode off, timer used: por held long, then released
    do_reset(MODE_OFF, 1'h0, 1'h1, 1'h1);
    // re-assert on the next edge, one driver assignment per time step
    @(posedge aclk);
    por_active <= 1'h1;
    cyc(40);
    @(negedge aclk);
    chk(core_reset_n, 1'h0);
    chk(brownout_level_out, 1'h1);
    chk(low_power_brownout_en, 1'h0);
    chk(brownout_detector_en, 1'h0);
    rdchk(CTRL_OFFS, 32'h80, RESP_OKAY);
    rdchk(STAT_OFFS, 32'h0, RESP_OKAY);
    por_active <= 1'h0;
    run_wait(n);
    chk(n >= PW && n <= PW + 15, 1'h1);
    wr(CTRL_OFFS, 32'hFF, RESP_OKAY);
    rdchk(CTRL_OFFS, 32'hC0, RESP_OKAY);
    // no byte lane 0: write answered but ignored
    s_axi_wstrb <= 4'h0;
    wr(CTRL_OFFS, 32'h0, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rdchk(CTRL_OFFS, 32'hC0, RESP_OKAY);
    @(negedge aclk);
    chk(bandgap_force_on, 1'h0);
    wr(4'h8, 32'h1, RESP_SLVERR);
    rdchk(4'h8, 32'h0, RESP_SLVERR);
    wr(STAT_OFFS, 32'h1, RESP_OKAY);
    rdchk(STAT_OFFS, 32'h3, RESP_OKAY);
    // pin reset while running, released after the pin delay
    ext_reset_pin_n <= 1'h0;
    cyc(30);
    @(negedge aclk);
    chk(core_reset_n, 1'h0);
    @(posedge aclk);
    ext_reset_pin_n <= 1'h1;
    run_wait(n);
    chk(n >= PIN_DLY_CYCLES && n <= PIN_DLY_CYCLES + 6, 1'h1);
    rdchk(STAT_OFFS, 32'h3, RESP_OKAY);
    rdchk(CTRL_OFFS, 32'hC0, RESP_OKAY);
    // software mode, timer bypassed, detector not ready
    do_reset(MODE_SOFTWARE, 1'h1, 1'h1, 1'h0);
    run_wait(n);
    chk(n < PW, 1'h1);
    rdchk(CTRL_OFFS, 32'h80, RESP_OKAY);
    @(negedge aclk);
    chk(brownout_detector_en, 1'h1);
    @(posedge aclk);
    brownout_circuit_ready <= 1'h1;
    cyc(5);
    rdchk(CTRL_OFFS, 32'h81, RESP_OKAY);
    wr(CTRL_OFFS, 32'h40, RESP_OKAY);
    @(negedge aclk);
    chk(brownout_detector_en, 1'h0);
    chk(bandgap_force_on, 1'h1);
    wr(CTRL_OFFS, 32'hC0, RESP_OKAY);
    sleep_mode <= 1'h1;
    cyc(5);
    @(negedge aclk);
    chk(brownout_detector_en, 1'h1);
    @(posedge aclk);
    sleep_mode <= 1'h0;
    low_power_brownout_below <= 1'h1;
    cyc(10);
    low_power_brownout_below <= 1'h0;
    @(negedge aclk);
    chk(core_reset_n, 1'h1);
    // short dip is filtered, long dip trips
    wr(STAT_OFFS, 32'h1, RESP_OKAY);
    brownout_below <= 1'h1;
    cyc(FILTER_CYCLES - 10);
    brownout_below <= 1'h0;
    cyc(5);
    @(negedge aclk);
    chk(core_reset_n, 1'h1);
    @(posedge aclk);
    brownout_below <= 1'h1;
    cyc(FILTER_CYCLES + 10);
    @(negedge aclk);
    chk(core_reset_n, 1'h0);
    chk(brownout_cause_n, 1'h0);
    @(posedge aclk);
    brownout_below <= 1'h0;
    run_wait(n);
    rdchk(CTRL_OFFS, 32'h81, RESP_OKAY);
    // always on: start waits for ready, sleep keeps detector
    do_reset(MODE_ALWAYS_ON, 1'h0, 1'h1, 1'h0);
    cyc(PW + 20);
    @(negedge aclk);
    chk(core_reset_n, 1'h0);
    chk(brownout_detector_en, 1'h1);
    @(posedge aclk);
    brownout_circuit_ready <= 1'h1;
    // other trip level, so a stuck level output shows up
    brownout_level_sel <= 1'h0;
    run_wait(n);
    chk(n < 10, 1'h1);
    wr(CTRL_OFFS, 32'h40, RESP_OKAY);
    sleep_mode <= 1'h1;
    cyc(5);
    @(negedge aclk);
    chk(bandgap_force_on, 1'h0);
    chk(brownout_detector_en, 1'h1);
    chk(wake_hold, 1'h0);
    chk(brownout_level_out, 1'h0);
    @(posedge aclk);
    sleep_mode <= 1'h0;
    // off in sleep, low-power detector enabled
    do_reset(MODE_OFF_SLEEP, 1'h1, 1'h0, 1'h0);
    cyc(30);
    @(negedge aclk);
    chk(core_reset_n, 1'h0);
    chk(low_power_brownout_en, 1'h1);
    @(posedge aclk);
    brownout_circuit_ready <= 1'h1;
    run_wait(n);
    wr(CTRL_OFFS, 32'h40, RESP_OKAY);
    sleep_mode <= 1'h1;
    cyc(5);
    @(negedge aclk);
    chk(brownout_detector_en, 1'h0);
    chk(bandgap_force_on, 1'h1);
    @(posedge aclk);
    sleep_mode <= 1'h0;
    brownout_circuit_ready <= 1'h0;
    cyc(5);
    @(negedge aclk);
    chk(wake_hold, 1'h1);
    @(posedge aclk);
    brownout_circuit_ready <= 1'h1;
    cyc(5);
    @(negedge aclk);
    chk(wake_hold, 1'h0);
    wr(STAT_OFFS, 32'h1, RESP_OKAY);
    low_power_brownout_below <= 1'h1;
    cyc(6);
    @(negedge aclk);
    chk(core_reset_n, 1'h0);
    chk(brownout_cause_n, 1'h0);
    @(posedge aclk);
    low_power_brownout_below <= 1'h0;
    run_wait(n);
    chk(core_reset_n, 1'h1);
    // pin function disabled: a low pin must not reset the core
    @(posedge aclk);
    ext_reset_enable <= 1'h0;
    ext_reset_pin_n <= 1'h0;
    cyc(10);
    @(negedge aclk);
    chk(core_reset_n, 1'h1);
    print_verdict;
  end

endmodule

// ---- verilog/rbs_pkg.sv ----
package rbs_pkg;

  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [3:0] CTRL_OFFS = 4'h0; // brownout_control
  localparam logic [3:0] STAT_OFFS = 4'h4; // cause flag and sequencer state

  // field positions in brownout_control
  localparam int CTRL_SWEN_BIT = 7; // sw_brownout_enable
  localparam int CTRL_FS_BIT = 6; // brownout_fast_start
  localparam int CTRL_RDY_BIT = 0; // brownout_ready_flag, read only

  // field positions in the status register
  localparam int STAT_CAUSE_BIT = 0; // brownout cause, low after a trip
  localparam int STAT_CORE_BIT = 1; // core running
  localparam int STAT_WAKE_BIT = 2; // wake-up held
  localparam int STAT_TRIP_BIT = 3; // filtered brown-out active

  // values after power-on or brown-out reset
  localparam logic SWEN_RST = 1'b1;
  localparam logic FS_RST = 1'b0;
  localparam logic CAUSE_RST = 1'b0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // brownout_mode_sel encodings
  // ----------------------------------------
  localparam logic [1:0] MODE_ALWAYS_ON = 2'h3;
  localparam logic [1:0] MODE_OFF_SLEEP = 2'h2;
  localparam logic [1:0] MODE_SOFTWARE = 2'h1;
  localparam logic [1:0] MODE_OFF = 2'h0;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 50000000;
  localparam int CLK_MHZ = CLK_HZ / 1000000;
  localparam int POWERUP_TIMER_TIME_MS = 64;
  localparam int POWERUP_TIMER_CYCLES_DEF = POWERUP_TIMER_TIME_MS * (CLK_HZ / 1000);
  localparam int POWERUP_TIMER_W = 22;
  localparam int FILTER_TIME_NS = 1000; // brownout_filter_time
  localparam int FILTER_CYCLES = (FILTER_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int FILT_W = 8;
  localparam int PIN_DLY_CYCLES = 10; // after a late pin release
  localparam int DLY_W = 4;

  // start-up sequencer states
  typedef enum logic [2:0] {
    ST_HOLD, ST_POWERUP_TIMER, ST_RDY, ST_PIN, ST_DLY, ST_RUN
  } rbs_state_t;

endpackage

// ---- verilog/rbs_reset_brownout_sequencer.sv ----
// Added by the designer: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps

module rbs_reset_brownout_sequencer #(
  parameter int POWERUP_TIMER_CYCLES = rbs_pkg::POWERUP_TIMER_CYCLES_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [rbs_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [rbs_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // analog detectors and reset pin, asynchronous
  input wire logic por_active,
  input wire logic brownout_below,
  input wire logic brownout_circuit_ready,
  input wire logic low_power_brownout_below,
  input wire logic ext_reset_pin_n,
  // configuration word bits, static
  input wire logic [1:0] brownout_mode_sel,
  input wire logic powerup_timer_disable_n,
  input wire logic brownout_level_sel,
  input wire logic low_power_brownout_n,
  input wire logic ext_reset_enable,
  // core side, same clock
  input wire logic sleep_mode,
  // outputs
  output logic core_reset_n,
  output logic wake_hold,
  output logic brownout_detector_en,
  output logic bandgap_force_on,
  output logic brownout_level_out,
  output logic low_power_brownout_en,
  output logic brownout_cause_n
);
  import rbs_pkg::*;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [4:0] meta_r; // first stage, read only by sync_r
  logic [4:0] sync_r; // second stage, safe to use
  wire [4:0] async_in = {ext_reset_pin_n, low_power_brownout_below,
                         brownout_circuit_ready, brownout_below, por_active};

  // two flops on every detector and the pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // idle levels: pin high, power-on active, so no false pin edge after reset
      meta_r <= 5'h11;
      sync_r <= 5'h11;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  wire por_s = sync_r[0];
  wire below_s = sync_r[1];
  wire rdy_s = sync_r[2];
  wire lp_below_s = sync_r[3];
  wire pin_n_s = sync_r[4];

  // ----------------------------------------
  // detector enable and ready flag
  // ----------------------------------------
  logic sw_en_r; // sw_brownout_enable
  logic fast_r; // brownout_fast_start
  logic det_en_r; // detector running
  logic ready_r; // brownout_ready_flag

  // enable bit acts in 01 only
  wire sw_mode = (brownout_mode_sel == MODE_SOFTWARE);
  wire det_en_nxt = (brownout_mode_sel == MODE_ALWAYS_ON) ||
                    (brownout_mode_sel == MODE_OFF_SLEEP && !sleep_mode) ||
                    (sw_mode && sw_en_r);
  // band-gap forced only in 10 and 01
  wire bg_nxt = fast_r && (brownout_mode_sel == MODE_OFF_SLEEP || sw_mode);
  wire ready_nxt = det_en_r && rdy_s;
  wire lp_en_nxt = !low_power_brownout_n;

  // detector controls to the analog side
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      det_en_r <= 1'b0;
      ready_r <= 1'b0;
      brownout_detector_en <= 1'b0;
      bandgap_force_on <= 1'b0;
      brownout_level_out <= 1'b0;
      low_power_brownout_en <= 1'b0;
    end else begin
      det_en_r <= det_en_nxt;
      ready_r <= ready_nxt;
      brownout_detector_en <= det_en_nxt;
      bandgap_force_on <= bg_nxt;
      brownout_level_out <= brownout_level_sel;
      low_power_brownout_en <= lp_en_nxt;
    end
  end

  // ----------------------------------------
  // noise filter and trip latches
  // ----------------------------------------
  logic [FILT_W-1:0] filt_cnt_r; // cycles spent below threshold
  logic trip_r; // filtered brown-out
  logic lp_trip_r; // low-power detector trip

  // protection starts once detector is ready
  wire protect = ready_r;
  wire dip = protect && below_s;
  // trip only when dip outlasts filter
  wire filt_done = (filt_cnt_r == FILT_W'(FILTER_CYCLES - 1));

  // short dips clear the count before it expires
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      filt_cnt_r <= '0;
      trip_r <= 1'b0;
      lp_trip_r <= 1'b0;
    end else begin
      filt_cnt_r <= (dip && !filt_done) ? filt_cnt_r + 1'b1 : (dip ? filt_cnt_r : '0);
      trip_r <= dip && (filt_done || trip_r);
      lp_trip_r <= lp_en_nxt && lp_below_s;
    end
  end

  // any source that counts as power-on or brown-out
  wire src_any = por_s || trip_r || lp_trip_r;

  // ----------------------------------------
  // start-up sequencer
  // ----------------------------------------
  rbs_state_t st_r;
  rbs_state_t st_nxt;
  logic [POWERUP_TIMER_W-1:0] powerup_timer_cnt_r; // power-up timer
  logic [DLY_W-1:0] dly_cnt_r; // late pin release delay

  // modes 11 and 10 make start-up wait on the detector
  wire wait_rdy = (brownout_mode_sel == MODE_ALWAYS_ON) ||
                  (brownout_mode_sel == MODE_OFF_SLEEP);
  wire pin_low = ext_reset_enable && !pin_n_s;
  wire powerup_timer_done = (powerup_timer_cnt_r == POWERUP_TIMER_W'(POWERUP_TIMER_CYCLES - 1));
  wire dly_done = (dly_cnt_r == DLY_W'(PIN_DLY_CYCLES - 1));
  // detector ready and supply above trip
  wire rdy_ok = ready_nxt && !below_s;
  wire powerup_timer_on = !powerup_timer_disable_n;

  // next state
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_HOLD: begin
        // timer starts once all sources release
        if (!src_any) begin
          st_nxt = powerup_timer_on ? ST_POWERUP_TIMER : ST_RDY;
        end
      end
      ST_POWERUP_TIMER: begin
        if (powerup_timer_done) begin
          st_nxt = ST_RDY;
        end
      end
      ST_RDY: begin
        if (!wait_rdy || rdy_ok) begin
          st_nxt = pin_low ? ST_PIN : ST_RUN;
        end
      end
      ST_PIN: begin
        if (!pin_low) begin
          st_nxt = ST_DLY;
        end
      end
      ST_DLY: begin
        if (dly_done) begin
          st_nxt = ST_RUN;
        end
      end
      default: begin
        // pin reset in normal run
        if (pin_low) begin
          st_nxt = ST_PIN;
        end
      end
    endcase
    // any power source restarts the sequence
    if (src_any) begin
      st_nxt = ST_HOLD;
    end
  end

  // state and counters
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= ST_HOLD;
      powerup_timer_cnt_r <= '0;
      dly_cnt_r <= '0;
    end else begin
      st_r <= st_nxt;
      powerup_timer_cnt_r <= (st_r == ST_POWERUP_TIMER && st_nxt == ST_POWERUP_TIMER) ? powerup_timer_cnt_r + 1'b1 : '0;
      dly_cnt_r <= (st_r == ST_DLY && st_nxt == ST_DLY) ? dly_cnt_r + 1'b1 : '0;
    end
  end

  // ----------------------------------------
  // core reset and wake-up hold
  // ----------------------------------------
  // mode 10 wake-up waits for ready
  wire wake_hold_nxt = (brownout_mode_sel == MODE_OFF_SLEEP) && !sleep_mode && !ready_nxt;

  // release on clock edge after all done
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_reset_n <= 1'b0;
      wake_hold <= 1'b0;
    end else begin
      core_reset_n <= (st_nxt == ST_RUN);
      wake_hold <= wake_hold_nxt;
    end
  end

  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------
  logic aw_held_r;
  logic w_held_r;
  logic [ADDR_W-1:0] waddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire b_done = s_axi_bvalid && s_axi_bready;
  wire aw_held_nxt = (aw_held_r || aw_take) && !b_done;
  wire w_held_nxt = (w_held_r || w_take) && !b_done;
  // write commits once both halves are in
  wire do_wr = aw_held_r && w_held_r && !s_axi_bvalid;
  wire wr_ctrl = do_wr && (waddr_r == CTRL_OFFS) && wstrb_r[0] == 1'b1;
  wire wr_stat = do_wr && (waddr_r == STAT_OFFS) && wstrb_r[0] == 1'b1;
  wire wr_hit = (waddr_r == CTRL_OFFS) || (waddr_r == STAT_OFFS);

  // address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      waddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else begin
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      s_axi_awready <= !aw_held_nxt;
      s_axi_wready <= !w_held_nxt;
      if (aw_take) begin
        waddr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (b_done) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // control and cause registers
  // ----------------------------------------
  // register bits held at reset value while a power source is active
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_en_r <= SWEN_RST;
      fast_r <= FS_RST;
      brownout_cause_n <= CAUSE_RST;
    end else begin
      // power-on or brown-out reload, others keep
      if (src_any) begin
        sw_en_r <= SWEN_RST;
        fast_r <= FS_RST;
      end else if (wr_ctrl) begin
        sw_en_r <= wdata_r[CTRL_SWEN_BIT];
        fast_r <= wdata_r[CTRL_FS_BIT];
      end
      // hardware clear beats a software set
      if (src_any) begin
        brownout_cause_n <= CAUSE_RST;
      end else if (wr_stat) begin
        brownout_cause_n <= wdata_r[STAT_CAUSE_BIT];
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  logic [31:0] rd_word;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire r_done = s_axi_rvalid && s_axi_rready;
  wire rvalid_nxt = ar_take || (s_axi_rvalid && !r_done);
  wire rd_ctrl = (s_axi_araddr == CTRL_OFFS);
  wire rd_stat = (s_axi_araddr == STAT_OFFS);

  // read word, unused bits zero
  always_comb begin
    rd_word = 32'h0;
    if (rd_ctrl) begin
      rd_word[CTRL_SWEN_BIT] = sw_en_r;
      rd_word[CTRL_FS_BIT] = fast_r;
      rd_word[CTRL_RDY_BIT] = ready_r;
    end else if (rd_stat) begin
      rd_word[STAT_CAUSE_BIT] = brownout_cause_n;
      rd_word[STAT_CORE_BIT] = core_reset_n;
      rd_word[STAT_WAKE_BIT] = wake_hold;
      rd_word[STAT_TRIP_BIT] = trip_r;
    end
  end

  // one read outstanding, answer one cycle after take
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_rvalid <= rvalid_nxt;
      s_axi_arready <= !rvalid_nxt;
      if (ar_take) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= (rd_ctrl || rd_stat) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence powerup_timer_running;
    st_r == ST_POWERUP_TIMER && !src_any && !powerup_timer_done;
  endsequence

  sequence late_pin_exit;
    st_r == ST_DLY && st_nxt == ST_RUN;
  endsequence

  core_hold_por_a: assert property (por_s |=> !core_reset_n)
    else $error("core released while power-on detector active");
  powerup_timer_holds_a: assert property (powerup_timer_running |=> st_r == ST_POWERUP_TIMER && !core_reset_n)
    else $error("power-up timer ended early");
  powerup_timer_bypass_a: assert property (st_r == ST_HOLD && !src_any && powerup_timer_disable_n |=> st_r != ST_POWERUP_TIMER)
    else $error("power-up timer ran while disabled");
  powerup_timer_start_a: assert property ($rose(st_r == ST_POWERUP_TIMER) |-> $past(!src_any))
    else $error("power-up timer started with a source active");
  rdy_wait_a: assert property (st_r == ST_RDY && wait_rdy && !rdy_ok && !src_any |=> st_r == ST_RDY)
    else $error("start-up did not wait for detector");
  mode_on_a: assert property (brownout_mode_sel == MODE_ALWAYS_ON ##1 brownout_mode_sel == MODE_ALWAYS_ON
                              |-> det_en_r && !wake_hold)
    else $error("always-on detector off or wake delayed");
  mode_off_a: assert property (brownout_mode_sel == MODE_OFF ##1 brownout_mode_sel == MODE_OFF
                               |-> !det_en_r && !ready_r)
    else $error("detector running in off mode");
  fast_start_a: assert property (bandgap_force_on |-> $past(fast_r) && ($past(brownout_mode_sel) == MODE_OFF_SLEEP ||
                                 $past(brownout_mode_sel) == MODE_SOFTWARE))
    else $error("band-gap forced without fast start");
  ready_flag_a: assert property (ready_r |-> $past(det_en_r) && $past(rdy_s))
    else $error("ready flag without active detector");
  filter_len_a: assert property ($rose(trip_r) |-> $past(filt_cnt_r) == FILT_W'(FILTER_CYCLES - 1))
    else $error("brown-out tripped before filter time");
  pin_delay_a: assert property (late_pin_exit |-> $past(st_r, 9) == ST_DLY && $past(st_r, 10) == ST_PIN)
    else $error("late pin release delay wrong");
  cause_clear_a: assert property (src_any |=> !brownout_cause_n ##1 (!brownout_cause_n || $past(wr_stat)))
    else $error("cause flag not cleared on power reset");

endmodule
